// File: bscd_defs.svh
// Purpose: Constants for the power-up strap decoder and its boot fetch engine
// Assumes: 50 MHz i_ref_clk, synchronous active high reset
// Notes:   Bit positions refer to the sampled pin vector in bscd_top
//
// Summary of operation
// - Slave address from data bits 1:0 straps: 0x24, 0x25, 0x34, 0x35.
// - Data bits 4:3 select none, I2C EEPROM, SPI memory, or reserved.
// - I2C memory: bit 5 low gives 11-bit addressing, high two address bytes.
// - SPI memory: bit 5 low sends two address bytes, high sends three.
// - Data bit 6 high mirrors the image horizontally, low keeps normal.
// - Data bit 7 high flips the image vertically, low keeps normal.
// - Data bit 8 low waits for external controller, high self-boots.
// - Data bit 9 low gives colour output, high black and white.
// - Overlay engine enabled while overlay pin high and shutdown input high, disabled otherwise.
// - Shutdown input low holds the device in hardware shutdown.
// - Multi-purpose pin one is frame sync input or IR-cut control one.
// - Boot master drives clock and select, reads data-in, shares data and clock.
// - Host writes through slave port can program the attached SPI memory.
// - Host may write every register over slave I2C, clocked at most 1 MHz.
// - Device drives a dedicated brown-out flag output.
`ifndef BSCD_DEFS_SVH
`define BSCD_DEFS_SVH

`define BSCD_ADDR_LL       7'h24
`define BSCD_ADDR_LH       7'h25
`define BSCD_ADDR_HL       7'h34
`define BSCD_ADDR_HH       7'h35

`define BSCD_PIN_D0        0
`define BSCD_PIN_D1        1
`define BSCD_PIN_D3        3
`define BSCD_PIN_D4        4
`define BSCD_PIN_D5        5
`define BSCD_PIN_D6        6
`define BSCD_PIN_D7        7
`define BSCD_PIN_D8        8
`define BSCD_PIN_D9        9
`define BSCD_PIN_HSYNC     10
`define BSCD_PIN_VSYNC     11
`define BSCD_PIN_OVERLAY   12
`define BSCD_PIN_SHDN_N    13
`define BSCD_PIN_FSYNC     14
`define BSCD_PIN_BROWNOUT  15
`define BSCD_PIN_MISO      16
`define BSCD_PIN_COUNT     17

`define BSCD_SPI_RD_CMD    8'h03
`define BSCD_SPI_HALF_DEF  8
`define BSCD_SPI_HALF_MIN  5
`define BSCD_SETTLE_CYC    4'h4
`define BSCD_BOOT_LEN_DEF  16
`define BSCD_SPI_AB_TWO    2'h2
`define BSCD_SPI_AB_THREE  2'h3

`endif

// File: bscd_pkg.sv
// Purpose: Types shared by the strap decoder modules
// Assumes: Nothing beyond the defs header
// Notes:   Encodings match the strap levels directly
package bscd_pkg;
	typedef enum logic [1:0] {
		BSCD_MEM_NONE = 2'h0,
		BSCD_MEM_I2C  = 2'h1,
		BSCD_MEM_SPI  = 2'h2,
		BSCD_MEM_RSVD = 2'h3
	} bscd_mem_t;

	typedef enum logic [2:0] {
		BSCD_ST_OFF    = 3'h0,
		BSCD_ST_SETTLE = 3'h1,
		BSCD_ST_IDLE   = 3'h2,
		BSCD_ST_CMD    = 3'h3,
		BSCD_ST_ADDR   = 3'h4,
		BSCD_ST_DATA   = 3'h5,
		BSCD_ST_PROG   = 3'h6
	} bscd_state_t;
endpackage

// File: bscd_spi_shift.sv
// Purpose: One-byte SPI mode 0 shifter with its own clock divider
// Assumes: MISO arrives already synchronised, four cycles late
// Notes:   Sampling at the end of the high phase absorbs the sync delay
`timescale 1ns/10ps
`include "bscd_defs.svh"
module bscd_spi_shift #(
	parameter int HALF = `BSCD_SPI_HALF_DEF
) (
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	// Byte request
	input  wire logic       i_start,
	input  wire logic [7:0] i_tx_byte,
	input  wire logic       i_miso,
	// Serial and status
	output logic            o_sck,
	output logic            o_mosi,
	output logic            o_busy,
	output logic            o_done,
	output logic [7:0]      o_rx_byte
);
	initial begin
		if (HALF < `BSCD_SPI_HALF_MIN || HALF > 255)
			$error("HALF out of range");
	end

	logic [7:0] cnt, next_cnt;
	logic [2:0] ph, next_ph;
	logic [7:0] sh, next_sh;
	logic [7:0] next_rx;
	logic       next_sck, next_mosi, next_busy, next_done;

	always_comb begin
		next_cnt  = cnt;
		next_ph   = ph;
		next_sh   = sh;
		next_rx   = o_rx_byte;
		next_sck  = o_sck;
		next_mosi = o_mosi;
		next_busy = o_busy;
		next_done = 1'b0;
		if (!o_busy) begin
			if (i_start) begin
				next_busy = 1'b1;
				next_sh   = i_tx_byte;
				next_mosi = i_tx_byte[7];
				next_ph   = 3'h0;
				next_cnt  = 8'h00;
				next_sck  = 1'b0;
			end
		end else if (cnt == 8'(HALF - 1)) begin
			next_cnt = 8'h00;
			if (!o_sck) begin
				next_sck = 1'b1;
			end else begin
				next_sck = 1'b0;
				next_rx  = {o_rx_byte[6:0], i_miso};
				if (ph == 3'h7) begin
					next_busy = 1'b0;
					next_done = 1'b1;
				end else begin
					next_ph   = ph + 3'h1;
					next_sh   = {sh[6:0], 1'b0};
					next_mosi = sh[6];
				end
			end
		end else begin
			next_cnt = cnt + 8'h01;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cnt       <= 8'h00;
			ph        <= 3'h0;
			sh        <= 8'h00;
			o_rx_byte <= 8'h00;
			o_sck     <= 1'b0;
			o_mosi    <= 1'b0;
			o_busy    <= 1'b0;
			o_done    <= 1'b0;
		end else begin
			cnt       <= next_cnt;
			ph        <= next_ph;
			sh        <= next_sh;
			o_rx_byte <= next_rx;
			o_sck     <= next_sck;
			o_mosi    <= next_mosi;
			o_busy    <= next_busy;
			o_done    <= next_done;
		end
	end
endmodule

// File: bscd_top.sv
// Purpose: Power-up strap decoder, shutdown control and SPI boot fetch
// Assumes: All pin inputs asynchronous to i_ref_clk
// Notes:   I2C boot memory is decoded only; its fetch lives elsewhere
`timescale 1ns/10ps
`include "bscd_defs.svh"
module bscd_top
	import bscd_pkg::*;
#(
	parameter int SPI_HALF = `BSCD_SPI_HALF_DEF,
	parameter int BOOT_LEN = `BSCD_BOOT_LEN_DEF
) (
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	// Strap and control pins
	input  wire logic [9:0] i_video_data_pin,
	input  wire logic       i_hsync_pin,
	input  wire logic       i_vsync_pin,
	input  wire logic       i_overlay_enable_pin,
	input  wire logic       i_hw_shutdown_n,
	input  wire logic       i_brownout_detect,
	// Register-side controls
	input  wire logic       i_flicker_reg_bit,
	input  wire logic       i_mpp1_is_frame_sync,
	input  wire logic       i_ir_cut_ctrl1,
	// Multi-purpose pin one
	input  wire logic       i_multi_purpose_pin_one,
	output logic            o_multi_purpose_pin_one,
	output logic            o_multi_purpose_pin_one_oe,
	// Boot memory pins
	output logic            o_boot_mem_select_n,
	output logic            o_boot_mem_clk_shared,
	input  wire logic       i_boot_mem_data_in,
	input  wire logic       i_boot_mem_data_out_shared,
	output logic            o_boot_mem_data_out_shared,
	output logic            o_boot_mem_data_out_shared_oe,
	// In-sensor programming from slave port
	input  wire logic       i_prog_mode,
	input  wire logic       i_prog_valid,
	input  wire logic [7:0] i_prog_byte,
	input  wire logic       i_prog_end,
	output logic            o_prog_ready,
	// Boot data stream
	output logic            o_boot_valid,
	output logic [7:0]      o_boot_byte,
	output logic            o_boot_done,
	// Decoded configuration
	output logic            o_config_valid,
	output logic            o_video_out_en,
	output logic [6:0]      o_slave_addr,
	output logic [1:0]      o_mem_type,
	output logic            o_i2c_addr_11bit,
	output logic [1:0]      o_spi_addr_bytes,
	output logic            o_mirror,
	output logic            o_flip,
	output logic            o_self_boot,
	output logic            o_mono,
	output logic            o_flicker_50hz,
	output logic            o_overlay_enable,
	output logic            o_shutdown,
	output logic            o_frame_sync_pulse,
	output logic            o_brownout_flag
);
	initial begin
		if (BOOT_LEN < 1 || BOOT_LEN > 65535)
			$error("BOOT_LEN out of range");
	end

	localparam int PW = `BSCD_PIN_COUNT;

	// Three flops, then accept once stages two and three agree
	logic [PW-1:0] pin_raw, s1, s2, s3, filt, next_filt;
	assign pin_raw = {i_boot_mem_data_in, i_brownout_detect, i_multi_purpose_pin_one,
	                  i_hw_shutdown_n, i_overlay_enable_pin, i_vsync_pin, i_hsync_pin,
	                  i_video_data_pin};

	genvar g;
	generate
		for (g = 0; g < PW; g++) begin : g_sync
			always_comb begin
				next_filt[g] = (s2[g] == s3[g]) ? s3[g] : filt[g];
			end
			always_ff @(posedge i_ref_clk) begin
				if (i_rst) begin
					s1[g]   <= 1'b0;
					s2[g]   <= 1'b0;
					s3[g]   <= 1'b0;
					filt[g] <= 1'b0;
				end else begin
					s1[g]   <= pin_raw[g];
					s2[g]   <= s1[g];
					s3[g]   <= s2[g];
					filt[g] <= next_filt[g];
				end
			end
		end
	endgenerate

	logic       pwr_on;
	logic       fs_prev;
	assign pwr_on = filt[`BSCD_PIN_SHDN_N];

	// Shutdown aborts a byte in flight, so SCK stops with chip select
	logic spi_rst;
	assign spi_rst = i_rst || !pwr_on;

	// SPI engine
	logic       spi_start, spi_sck, spi_mosi, spi_busy, spi_done;
	logic [7:0] spi_tx, spi_rx;

	bscd_spi_shift #(
		.HALF (SPI_HALF)
	) u_spi (
		.i_ref_clk (i_ref_clk),
		.i_rst     (spi_rst),
		.i_start   (spi_start),
		.i_tx_byte (spi_tx),
		.i_miso    (filt[`BSCD_PIN_MISO]),
		.o_sck     (spi_sck),
		.o_mosi    (spi_mosi),
		.o_busy    (spi_busy),
		.o_done    (spi_done),
		.o_rx_byte (spi_rx)
	);

	bscd_state_t state, next_state;
	logic [3:0]  settle, next_settle;
	logic [15:0] cnt, next_cnt;
	logic        issued, next_issued;
	logic        next_spi_start;
	logic [7:0]  next_spi_tx;
	logic        next_cs_n, next_boot_valid, next_boot_done, next_prog_ready;
	logic        next_cfg_valid;
	logic [6:0]  next_addr;
	logic [1:0]  next_mem, flk_strap, next_flk_strap;
	logic        next_asel, next_mirror, next_flip, next_self, next_mono;
	// D5 strap kept on its own; the 11-bit flag alone loses it for SPI
	logic        asel;

	always_comb begin
		next_state      = state;
		next_settle     = settle;
		next_cnt        = cnt;
		next_issued     = issued;
		next_spi_start  = 1'b0;
		next_spi_tx     = spi_tx;
		next_cs_n       = o_boot_mem_select_n;
		next_boot_valid = 1'b0;
		next_boot_done  = o_boot_done;
		next_prog_ready = 1'b0;
		next_cfg_valid  = o_config_valid;
		next_addr       = o_slave_addr;
		next_mem        = o_mem_type;
		next_asel       = asel;
		next_mirror     = o_mirror;
		next_flip       = o_flip;
		next_self       = o_self_boot;
		next_mono       = o_mono;
		next_flk_strap  = flk_strap;
		case (state)
			BSCD_ST_OFF: begin
				next_settle = 4'h0;
				if (pwr_on)
					next_state = BSCD_ST_SETTLE;
			end
			BSCD_ST_SETTLE: begin
				next_settle = settle + 4'h1;
				if (settle == `BSCD_SETTLE_CYC) begin
					// One capture only; straps become video outputs after
					case (filt[`BSCD_PIN_D1:`BSCD_PIN_D0])
						2'h0:    next_addr = `BSCD_ADDR_LL;
						2'h1:    next_addr = `BSCD_ADDR_LH;
						2'h2:    next_addr = `BSCD_ADDR_HL;
						default: next_addr = `BSCD_ADDR_HH;
					endcase
					next_mem       = filt[`BSCD_PIN_D4:`BSCD_PIN_D3];
					next_asel      = !filt[`BSCD_PIN_D5];
					next_mirror    = filt[`BSCD_PIN_D6];
					next_flip      = filt[`BSCD_PIN_D7];
					next_self      = filt[`BSCD_PIN_D8];
					next_mono      = filt[`BSCD_PIN_D9];
					next_flk_strap = {filt[`BSCD_PIN_VSYNC], filt[`BSCD_PIN_HSYNC]};
					next_cfg_valid = 1'b1;
					next_state     = BSCD_ST_IDLE;
					// Only SPI memory self-boot is fetched here
					if (filt[`BSCD_PIN_D8] && filt[`BSCD_PIN_D4:`BSCD_PIN_D3] == BSCD_MEM_SPI)
						next_state = BSCD_ST_CMD;
				end
			end
			BSCD_ST_CMD, BSCD_ST_ADDR, BSCD_ST_DATA, BSCD_ST_PROG: begin
				next_cs_n = 1'b0;
				if (!issued) begin
					next_issued    = 1'b1;
					next_spi_start = 1'b1;
					next_spi_tx    = (state == BSCD_ST_CMD) ? `BSCD_SPI_RD_CMD :
					                 (state == BSCD_ST_PROG) ? spi_tx : 8'h00;
				end else if (spi_done) begin
					next_issued = 1'b0;
					next_cnt    = cnt + 16'h0001;
					case (state)
						BSCD_ST_CMD: begin
							next_cnt   = 16'h0000;
							next_state = BSCD_ST_ADDR;
						end
						BSCD_ST_ADDR: begin
							// Address bytes follow the latched width
							if (cnt[1:0] == o_spi_addr_bytes - 2'h1) begin
								next_cnt   = 16'h0000;
								next_state = BSCD_ST_DATA;
							end
						end
						BSCD_ST_DATA: begin
							next_boot_valid = 1'b1;
							if (cnt == 16'(BOOT_LEN - 1)) begin
								next_cs_n      = 1'b1;
								next_boot_done = 1'b1;
								next_state     = BSCD_ST_IDLE;
							end
						end
						default: next_state = BSCD_ST_IDLE;
					endcase
				end
			end
			BSCD_ST_IDLE: begin
				// Host bytes arrive from the slave I2C register path
				if (i_prog_mode && o_mem_type == BSCD_MEM_SPI) begin
					if (i_prog_end)
						next_cs_n = 1'b1;
					else if (i_prog_valid && o_prog_ready) begin
						next_spi_tx = i_prog_byte;
						next_state  = BSCD_ST_PROG;
					end else
						next_prog_ready = 1'b1;
				end else
					next_cs_n = 1'b1;
			end
			default: next_state = BSCD_ST_OFF;
		endcase
		if (!pwr_on) begin
			next_state     = BSCD_ST_OFF;
			next_issued    = 1'b0;
			next_cnt       = 16'h0000;
			next_cs_n      = 1'b1;
			next_cfg_valid = 1'b0;
			next_boot_done = 1'b0;
			next_prog_ready = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state               <= BSCD_ST_OFF;
			settle              <= 4'h0;
			cnt                 <= 16'h0000;
			issued              <= 1'b0;
			spi_start           <= 1'b0;
			spi_tx              <= 8'h00;
			o_boot_mem_select_n <= 1'b1;
			o_boot_valid        <= 1'b0;
			o_boot_byte         <= 8'h00;
			o_boot_done         <= 1'b0;
			o_prog_ready        <= 1'b0;
			o_config_valid      <= 1'b0;
			o_video_out_en      <= 1'b0;
			o_slave_addr        <= `BSCD_ADDR_LL;
			o_mem_type          <= BSCD_MEM_NONE;
			o_i2c_addr_11bit    <= 1'b0;
			asel                <= 1'b1;
			o_spi_addr_bytes    <= `BSCD_SPI_AB_TWO;
			o_mirror            <= 1'b0;
			o_flip              <= 1'b0;
			o_self_boot         <= 1'b0;
			o_mono              <= 1'b0;
			flk_strap           <= 2'h0;
		end else begin
			state               <= next_state;
			settle              <= next_settle;
			cnt                 <= next_cnt;
			issued              <= next_issued;
			spi_start           <= next_spi_start;
			spi_tx              <= next_spi_tx;
			o_boot_mem_select_n <= next_cs_n;
			o_boot_valid        <= next_boot_valid;
			o_boot_byte         <= next_boot_valid ? spi_rx : o_boot_byte;
			o_boot_done         <= next_boot_done;
			o_prog_ready        <= next_prog_ready;
			o_config_valid      <= next_cfg_valid;
			o_video_out_en      <= next_cfg_valid;
			o_slave_addr        <= next_addr;
			o_mem_type          <= next_mem;
			o_i2c_addr_11bit    <= next_asel && (next_mem == BSCD_MEM_I2C);
			asel                <= next_asel;
			o_spi_addr_bytes    <= next_asel ? `BSCD_SPI_AB_TWO : `BSCD_SPI_AB_THREE;
			o_mirror            <= next_mirror;
			o_flip              <= next_flip;
			o_self_boot         <= next_self;
			o_mono              <= next_mono;
			flk_strap           <= next_flk_strap;
		end
	end

	// Live pin functions and boot pin drive
	logic next_fs_pulse, next_flk50, next_mem_oe;
	always_comb begin
		next_fs_pulse = i_mpp1_is_frame_sync && filt[`BSCD_PIN_FSYNC] && !fs_prev;
		// Vsync strap high hands the choice to the register bit
		next_flk50    = flk_strap[1] ? i_flicker_reg_bit : flk_strap[0];
		next_mem_oe   = pwr_on && o_mem_type == BSCD_MEM_SPI;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			fs_prev                       <= 1'b0;
			o_frame_sync_pulse            <= 1'b0;
			o_flicker_50hz                <= 1'b0;
			o_overlay_enable              <= 1'b0;
			o_shutdown                    <= 1'b1;
			o_brownout_flag               <= 1'b0;
			o_multi_purpose_pin_one       <= 1'b0;
			o_multi_purpose_pin_one_oe    <= 1'b0;
			o_boot_mem_clk_shared         <= 1'b0;
			o_boot_mem_data_out_shared    <= 1'b0;
			o_boot_mem_data_out_shared_oe <= 1'b0;
		end else begin
			fs_prev                       <= filt[`BSCD_PIN_FSYNC];
			o_frame_sync_pulse            <= next_fs_pulse;
			o_flicker_50hz                <= next_flk50;
			o_overlay_enable              <= filt[`BSCD_PIN_OVERLAY] && pwr_on;
			o_shutdown                    <= !pwr_on;
			o_brownout_flag               <= filt[`BSCD_PIN_BROWNOUT];
			o_multi_purpose_pin_one       <= i_ir_cut_ctrl1;
			o_multi_purpose_pin_one_oe    <= !i_mpp1_is_frame_sync && pwr_on;
			o_boot_mem_clk_shared         <= spi_sck;
			o_boot_mem_data_out_shared    <= spi_mosi;
			o_boot_mem_data_out_shared_oe <= next_mem_oe;
		end
	end
endmodule

// File: bscd_top_asserts.sv
// Purpose: Port-level checks on the strap decoder top
// Assumes: Bound to bscd_top, one clock domain
// Notes:   Forms tolerate a cycle of output lag after shutdown
`timescale 1ns/10ps
module bscd_top_asserts
	import bscd_pkg::*;
(
	// Clock and reset
	input wire logic       i_ref_clk,
	input wire logic       i_rst,
	// Watched controls
	input wire logic       i_mpp1_is_frame_sync,
	input wire logic       i_prog_mode,
	// Watched outputs
	input wire logic       o_multi_purpose_pin_one_oe,
	input wire logic       o_boot_mem_select_n,
	input wire logic       o_boot_mem_data_out_shared_oe,
	input wire logic       o_boot_valid,
	input wire logic       o_boot_done,
	input wire logic       o_config_valid,
	input wire logic [6:0] o_slave_addr,
	input wire logic [1:0] o_mem_type,
	input wire logic       o_i2c_addr_11bit,
	input wire logic [1:0] o_spi_addr_bytes,
	input wire logic       o_mirror,
	input wire logic       o_flip,
	input wire logic       o_self_boot,
	input wire logic       o_mono,
	input wire logic       o_shutdown,
	input wire logic       o_frame_sync_pulse
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	a_cfg_frozen: assert property (o_config_valid && $past(o_config_valid) |->
		$stable({o_slave_addr, o_mem_type, o_spi_addr_bytes, o_mirror, o_flip, o_self_boot, o_mono}))
		else $error("latched configuration changed");
	a_shut_quiet: assert property (o_shutdown |=> !o_config_valid && !o_boot_done)
		else $error("configuration kept during shutdown");
	a_addr_set: assert property (o_slave_addr inside {7'h24, 7'h25, 7'h34, 7'h35})
		else $error("slave address outside the strap set");
	a_i2c_only: assert property (o_i2c_addr_11bit |-> o_mem_type == BSCD_MEM_I2C)
		else $error("11-bit addressing without I2C memory");
	a_ab_range: assert property (o_spi_addr_bytes inside {2'h2, 2'h3})
		else $error("bad SPI address byte count");
	a_cs_cause: assert property ($fell(o_boot_mem_select_n) |-> o_config_valid
		&& o_mem_type == BSCD_MEM_SPI && (o_self_boot || $past(i_prog_mode)))
		else $error("chip select without SPI boot");
	a_cs_hold: assert property ($fell(o_boot_mem_select_n) |=> !o_boot_mem_select_n [*3])
		else $error("chip select pulse too short");
	a_mosi_oe: assert property ($rose(o_boot_mem_data_out_shared_oe) |->
		o_mem_type == BSCD_MEM_SPI && !o_shutdown)
		else $error("data pin driven without SPI memory");
	a_boot_gap: assert property (o_boot_valid |=> !o_boot_valid [*8])
		else $error("boot bytes too close");
	a_fs_pulse: assert property (o_frame_sync_pulse |=> !o_frame_sync_pulse)
		else $error("frame sync pulse too long");
	a_mpp_input: assert property (i_mpp1_is_frame_sync [*3] |-> !o_multi_purpose_pin_one_oe)
		else $error("pin driven in frame sync mode");

	c_latch: cover property ($rose(o_config_valid));
	c_boot: cover property ($rose(o_boot_done));
	c_fsync: cover property (o_frame_sync_pulse);
endmodule

bind bscd_top bscd_top_asserts i_chk (.i_ref_clk, .i_rst, .i_mpp1_is_frame_sync, .i_prog_mode,
	.o_multi_purpose_pin_one_oe, .o_boot_mem_select_n, .o_boot_mem_data_out_shared_oe,
	.o_boot_valid, .o_boot_done, .o_config_valid, .o_slave_addr, .o_mem_type,
	.o_i2c_addr_11bit, .o_spi_addr_bytes, .o_mirror, .o_flip, .o_self_boot, .o_mono,
	.o_shutdown, .o_frame_sync_pulse);

// File: bscd_mem_model.sv
// Purpose: Behavioural SPI boot memory, mode 0
// Assumes: Data byte n reads as 0xC3 plus n
// Notes:   Data line falls to its pull-down while not driven
`timescale 1ns/10ps
module bscd_mem_model (
	// Serial bus from the boot master
	input  wire logic       i_cs_n,
	input  wire logic       i_sck,
	input  wire logic       i_mosi,
	input  wire logic [1:0] i_addr_bytes,
	// Read data and captured command
	output logic            o_miso,
	output logic [7:0]      o_cmd
);
	int         rises = 0;
	int         d;
	logic [7:0] b;

	initial o_miso = 1'b0;
	initial o_cmd = 8'h00;
	always @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			rises = 0;
		end else begin
			if (rises < 8)
				o_cmd = {o_cmd[6:0], i_mosi};
			rises++;
		end
	end
	// Header length follows the strapped address width
	always @(negedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			o_miso = 1'b0;
		end else begin
			d = rises - 8 * (1 + i_addr_bytes);
			b = 8'hC3 + 8'(d / 8);
			o_miso = (d >= 0) ? b[7 - (d % 8)] : 1'b0;
		end
	end
endmodule

// File: bscd_top_tb.sv
// Purpose: Self-checking bench for the strap decoder top
// Assumes: Short SPI half period and two boot bytes
// Notes:   Straps drawn from a fixed-seed xorshift
`timescale 1ns/10ps
module bscd_top_tb;
	import bscd_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [9:0]  vd = 10'h000;
	logic        hs = 1'b0, vs = 1'b0, ov = 1'b0, sd_n = 1'b0, bo = 1'b0, fr = 1'b0;
	logic        fs_mode = 1'b1, irc = 1'b0, mpp = 1'b0;
	logic [1:0]  ab = 2'h2;
	logic        prog_mode = 1'b0, prog_valid = 1'b0, prog_end = 1'b0, prog_rdy, ven;
	logic [7:0]  prog_byte = 8'h00;
	logic        mpp_o, mpp_oe, cs_n, sck, miso, mosi, mosi_oe, o_boot_valid, o_boot_done;
	logic        o_config_valid, o_i2c_addr_11bit, o_mirror, o_flip, o_self_boot, o_mono;
	logic        o_flicker_50hz, o_overlay_enable, o_shutdown, o_frame_sync_pulse, o_brownout_flag;
	logic [6:0]  o_slave_addr;
	logic [1:0]  o_mem_type, o_spi_addr_bytes;
	logic [7:0]  o_boot_byte, cmd;
	logic [31:0] seed = 32'h0000_0017;
	int          n_mismatch = 0;
	int          cmp_count = 0;

	always #10 clk = ~clk;
	bscd_top #(.SPI_HALF(5), .BOOT_LEN(2)) i_bscd_top (.i_ref_clk(clk), .i_rst(rst),
		.i_video_data_pin(vd), .i_hsync_pin(hs), .i_vsync_pin(vs), .i_overlay_enable_pin(ov),
		.i_hw_shutdown_n(sd_n), .i_brownout_detect(bo), .i_flicker_reg_bit(fr),
		.i_mpp1_is_frame_sync(fs_mode), .i_ir_cut_ctrl1(irc),
		.i_multi_purpose_pin_one(mpp_oe ? mpp_o : mpp), .o_multi_purpose_pin_one(mpp_o),
		.o_multi_purpose_pin_one_oe(mpp_oe), .o_boot_mem_select_n(cs_n),
		.o_boot_mem_clk_shared(sck), .i_boot_mem_data_in(miso),
		.i_boot_mem_data_out_shared(mosi_oe ? mosi : 1'b0),
		.o_boot_mem_data_out_shared(mosi), .o_boot_mem_data_out_shared_oe(mosi_oe),
		.i_prog_mode(prog_mode), .i_prog_valid(prog_valid), .i_prog_byte(prog_byte),
		.i_prog_end(prog_end), .o_prog_ready(prog_rdy), .o_boot_valid, .o_boot_byte,
		.o_boot_done, .o_config_valid,
		.o_video_out_en(ven), .o_slave_addr, .o_mem_type, .o_i2c_addr_11bit, .o_spi_addr_bytes,
		.o_mirror, .o_flip, .o_self_boot, .o_mono, .o_flicker_50hz, .o_overlay_enable,
		.o_shutdown, .o_frame_sync_pulse, .o_brownout_flag);
	bscd_mem_model i_bscd_mem_model (.i_cs_n(cs_n), .i_sck(sck), .i_mosi(mosi),
		.i_addr_bytes(ab), .o_miso(miso), .o_cmd(cmd));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] exp_addr(input logic [1:0] s);
		case (s)
			2'h0: return 8'h24;
			2'h1: return 8'h25;
			2'h2: return 8'h34;
			default: return 8'h35;
		endcase
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Straps must stand through the sync and settle time
	task automatic power_cycle(input logic [9:0] d, input logic [31:0] r);
		int k;
		@(posedge clk) sd_n <= 1'b0;
		tick(8);
		chk(o_config_valid, 8'h00);
		chk(o_shutdown, 8'h01);
		chk(ven, 8'h00);
		@(posedge clk) begin
			vd <= d;
			hs <= r[10];
			vs <= r[11];
			fr <= r[12];
		end
		tick(4);
		@(posedge clk) sd_n <= 1'b1;
		for (k = 0; k < 40 && o_config_valid !== 1'b1; k++)
			tick(1);
		// Flicker output settles one cycle after the latch
		tick(1);
		chk(o_config_valid, 8'h01);
		chk(ven, 8'h01);
	endtask
	task automatic check_cfg(input logic [9:0] d, input logic [31:0] r);
		chk(o_slave_addr, exp_addr(d[1:0]));
		chk(o_mem_type, d[4:3]);
		chk(o_i2c_addr_11bit, d[4:3] == 2'h1 && !d[5]);
		chk(o_spi_addr_bytes, d[5] ? 2'h3 : 2'h2);
		chk(o_mirror, d[6]);
		chk(o_flip, d[7]);
		chk(o_self_boot, d[8]);
		chk(o_mono, d[9]);
		chk(o_flicker_50hz, r[11] ? r[12] : r[10]);
	endtask

	initial begin
		logic [31:0] r;
		logic [9:0]  d;
		int          n;
		tick(19);
		chk(o_shutdown, 8'h01);
		chk(cs_n, 8'h01);
		chk(o_slave_addr, 8'h24);
		chk(o_spi_addr_bytes, 8'h02);
		@(posedge clk) rst <= 1'b0;
		for (int i = 0; i < 24; i++) begin
			r = rnd();
			d = r[9:0];
			if (i < 4) begin
				d[1:0] = i[1:0];
				d[4:3] = i[1:0];
			end
			power_cycle(d, r);
			check_cfg(d, r);
			@(posedge clk) begin
				vd <= ~d;
				hs <= ~r[10];
				vs <= ~r[11];
				ov <= r[13];
				bo <= r[14];
			end
			tick(10);
			check_cfg(d, r);
			chk(o_overlay_enable, r[13]);
			chk(o_brownout_flag, r[14]);
			chk(mosi_oe, d[4:3] == 2'h2);
		end
		for (int j = 0; j < 2; j++) begin
			@(posedge clk) ab <= j[0] ? 2'h3 : 2'h2;
			power_cycle({1'b0, 1'b1, 2'b00, j[0], 5'b10000}, 32'h0);
			for (int k = 0; k < 2; k++) begin
				for (n = 0; n < 2000 && o_boot_valid !== 1'b1; n++)
					tick(1);
				chk(o_boot_byte, 8'hC3 + 8'(k));
				tick(1);
			end
			for (n = 0; n < 50 && o_boot_done !== 1'b1; n++)
				tick(1);
			chk(o_boot_done, 8'h01);
			chk(cmd, 8'h03);
			chk(mosi_oe, 8'h01);
		end
		// Host byte through the slave path lands in the SPI memory
		r = rnd();
		@(posedge clk) prog_mode <= 1'b1;
		for (n = 0; n < 20 && prog_rdy !== 1'b1; n++)
			tick(1);
		chk(prog_rdy, 8'h01);
		@(posedge clk) begin
			prog_valid <= 1'b1;
			prog_byte  <= r[7:0];
		end
		@(posedge clk) prog_valid <= 1'b0;
		tick(1);
		chk(prog_rdy, 8'h00);
		for (n = 0; n < 200 && prog_rdy !== 1'b1; n++)
			tick(1);
		chk(cmd, r[7:0]);
		chk(cs_n, 8'h00);
		@(posedge clk) prog_end <= 1'b1;
		tick(2);
		chk(cs_n, 8'h01);
		@(posedge clk) begin
			prog_end  <= 1'b0;
			prog_mode <= 1'b0;
		end
		@(posedge clk) mpp <= 1'b1;
		n = 0;
		repeat (12) begin
			tick(1);
			n += (o_frame_sync_pulse === 1'b1);
		end
		chk(8'(n), 8'h01);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk) begin
				fs_mode <= 1'b0;
				irc <= v[0];
			end
			tick(4);
			chk(mpp_oe, 8'h01);
			chk(mpp_o, v[0]);
		end
		conclude();
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		conclude();
	end
endmodule
